// [ssr_pkg.sv]
`default_nettype none
package ssr_pkg;
    // Register offsets (byte addresses)
    localparam logic [11:0] ADDR_DATA = 12'h008;
    localparam logic [11:0] ADDR_STATUS = 12'h00c;
    localparam logic [11:0] ADDR_CPSR = 12'h010;
    localparam logic [11:0] ADDR_IMASK = 12'h014;
    localparam logic [11:0] ADDR_RIS = 12'h018;
    localparam logic [11:0] ADDR_MIS = 12'h01c;
    localparam logic [11:0] ADDR_ICR = 12'h020;
    // Status bit positions
    localparam int ST_BUSY = 4;
    localparam int ST_RFF = 3;
    localparam int ST_RNE = 2;
    localparam int ST_TNF = 1;
    localparam int ST_TFE = 0;
    // Interrupt bit positions, shared by mask, raw, masked and clear
    localparam int IRQ_TX = 3;
    localparam int IRQ_RX = 2;
    localparam int IRQ_RT = 1;
    localparam int IRQ_ROR = 0;
    // Field widths, reset values and the minimum prescale divisor
    localparam int DATA_W = 16;
    localparam int CPSR_W = 8;
    localparam int IRQ_W = 4;
    localparam logic [7:0] CPSR_RST = 8'h00;
    localparam logic [3:0] IMASK_RST = 4'h0;
    localparam logic [7:0] CPSR_MIN = 8'h02;
    // Receive timeout, in serial bit periods
    localparam int RX_TIMEOUT_BITS = 32;
endpackage
`default_nettype wire

// [ssr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_regs
    import ssr_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    output logic [31:0] reg_rdata_o,
    input wire logic port_enable_i,
    input wire logic [3:0] frame_size_select_i,
    input wire logic [7:0] serial_clock_rate_i,
    input wire logic frame_active_i,
    output logic bit_tick_o,
    output logic tx_valid_o,
    output logic [15:0] tx_data_o,
    input wire logic tx_pop_i,
    input wire logic rx_valid_i,
    input wire logic [15:0] rx_data_i,
    output logic tx_fifo_irq_o,
    output logic rx_fifo_irq_o,
    output logic rx_timeout_irq_o,
    output logic rx_overrun_irq_o
);
    localparam int PW = (FIFO_DEPTH > 1) ? $clog2(FIFO_DEPTH) : 1;
    localparam int CW = $clog2(FIFO_DEPTH + 1);
    localparam int TW = $clog2(RX_TIMEOUT_BITS + 1);
    localparam logic [CW-1:0] CNT_FULL = CW'(FIFO_DEPTH);
    localparam logic [CW-1:0] CNT_HALF = CW'(FIFO_DEPTH / 2);
    localparam logic [TW-1:0] TO_LAST = TW'(RX_TIMEOUT_BITS - 1);
    localparam logic [PW-1:0] PTR_LAST = PW'(FIFO_DEPTH - 1);

    typedef struct packed {
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] tx_mem;
        logic [PW-1:0] tx_wp;
        logic [PW-1:0] tx_rp;
        logic [CW-1:0] tx_cnt;
        logic [FIFO_DEPTH-1:0][DATA_W-1:0] rx_mem;
        logic [PW-1:0] rx_wp;
        logic [PW-1:0] rx_rp;
        logic [CW-1:0] rx_cnt;
        logic [CPSR_W-1:0] cpsr;
        logic [IRQ_W-1:0] imask;
        logic rt_raw;
        logic ror_raw;
        logic [CPSR_W-1:0] pre_cnt;
        logic [7:0] scr_cnt;
        logic [TW-1:0] to_cnt;
        logic tick;
        logic [31:0] rdata;
    } ssr_state_s;

    ssr_state_s state_reg;
    ssr_state_s state_next;

    // Keep-mask of the configured frame width
    logic [DATA_W-1:0] frame_mask;
    genvar gi;
    generate
        for (gi = 0; gi < DATA_W; gi++) begin : g_mask
            assign frame_mask[gi] = (4'(gi) <= frame_size_select_i);
        end
    endgenerate

    logic [IRQ_W-1:0] irq_raw;
    logic [IRQ_W-1:0] irq_masked;
    logic tx_empty;
    logic tx_full;
    logic rx_empty;
    logic rx_full;

    assign tx_empty = (state_reg.tx_cnt == '0);
    assign tx_full = (state_reg.tx_cnt == CNT_FULL);
    assign rx_empty = (state_reg.rx_cnt == '0);
    assign rx_full = (state_reg.rx_cnt == CNT_FULL);

    always_comb begin
        irq_raw = '0;
        irq_raw[IRQ_TX] = (state_reg.tx_cnt <= CNT_HALF);
        irq_raw[IRQ_RX] = (state_reg.rx_cnt >= CNT_HALF);
        irq_raw[IRQ_RT] = state_reg.rt_raw;
        irq_raw[IRQ_ROR] = state_reg.ror_raw;
    end

    assign irq_masked = irq_raw & state_reg.imask;

    always_comb begin
        logic wr_ok;
        logic rd_ok;
        logic tx_push;
        logic tx_pop;
        logic rx_push;
        logic rx_pop;
        logic pre_wrap;
        logic scr_wrap;
        logic tick;
        wr_ok = 1'b0;
        rd_ok = 1'b0;
        tx_push = 1'b0;
        tx_pop = 1'b0;
        rx_push = 1'b0;
        rx_pop = 1'b0;
        pre_wrap = 1'b0;
        scr_wrap = 1'b0;
        tick = 1'b0;
        state_next = state_reg;
        wr_ok = ce_i & reg_wr_i;
        rd_ok = ce_i & reg_rd_i;

        // Transmit FIFO; writes into a full FIFO are dropped
        tx_push = wr_ok && (reg_addr_i == ADDR_DATA) && !tx_full;
        tx_pop = ce_i && tx_pop_i && !tx_empty;
        if (tx_push) begin
            // Upper bits cleared so the shifter never sees them
            state_next.tx_mem[state_reg.tx_wp] = reg_wdata_i[DATA_W-1:0] & frame_mask;
            state_next.tx_wp = (state_reg.tx_wp == PTR_LAST) ? '0 : state_reg.tx_wp + 1'b1;
        end
        if (tx_pop) begin
            state_next.tx_rp = (state_reg.tx_rp == PTR_LAST) ? '0 : state_reg.tx_rp + 1'b1;
        end
        if (tx_push && !tx_pop) begin
            state_next.tx_cnt = state_reg.tx_cnt + 1'b1;
        end else if (tx_pop && !tx_push) begin
            state_next.tx_cnt = state_reg.tx_cnt - 1'b1;
        end

        // Receive FIFO; a pop in the same cycle frees room for the push
        rx_pop = rd_ok && (reg_addr_i == ADDR_DATA) && !rx_empty;
        rx_push = ce_i && rx_valid_i && (!rx_full || rx_pop);
        if (rx_push) begin
            state_next.rx_mem[state_reg.rx_wp] = rx_data_i & frame_mask;
            state_next.rx_wp = (state_reg.rx_wp == PTR_LAST) ? '0 : state_reg.rx_wp + 1'b1;
        end
        if (rx_pop) begin
            state_next.rx_rp = (state_reg.rx_rp == PTR_LAST) ? '0 : state_reg.rx_rp + 1'b1;
        end
        if (rx_push && !rx_pop) begin
            state_next.rx_cnt = state_reg.rx_cnt + 1'b1;
        end else if (rx_pop && !rx_push) begin
            state_next.rx_cnt = state_reg.rx_cnt - 1'b1;
        end

        // Bit-rate divider; a divisor below two stops the clock
        if (ce_i && port_enable_i && (state_reg.cpsr >= CPSR_MIN)) begin
            pre_wrap = (state_reg.pre_cnt >= state_reg.cpsr - 1'b1);
            scr_wrap = (state_reg.scr_cnt >= serial_clock_rate_i);
            state_next.pre_cnt = pre_wrap ? '0 : state_reg.pre_cnt + 1'b1;
            if (pre_wrap) begin
                state_next.scr_cnt = scr_wrap ? '0 : state_reg.scr_cnt + 1'b1;
            end
            tick = pre_wrap & scr_wrap;
        end else if (ce_i) begin
            state_next.pre_cnt = '0;
            state_next.scr_cnt = '0;
        end
        if (ce_i) begin
            state_next.tick = tick;
        end

        // Receive timeout counts bit periods of unread data
        if (ce_i) begin
            if (rx_empty || rx_pop) begin
                state_next.to_cnt = '0;
            end else if (tick) begin
                state_next.to_cnt = (state_reg.to_cnt == TO_LAST) ? '0 : state_reg.to_cnt + 1'b1;
            end
        end

        // Sticky sources: a set in the clearing cycle wins
        if (wr_ok && (reg_addr_i == ADDR_ICR)) begin
            if (reg_wdata_i[IRQ_RT]) begin
                state_next.rt_raw = 1'b0;
            end
            if (reg_wdata_i[IRQ_ROR]) begin
                state_next.ror_raw = 1'b0;
            end
        end
        if (ce_i && !rx_empty && !rx_pop && tick && (state_reg.to_cnt == TO_LAST)) begin
            state_next.rt_raw = 1'b1;
        end
        if (ce_i && rx_valid_i && rx_full && !rx_pop) begin
            state_next.ror_raw = 1'b1;
        end

        // Writable registers; status and interrupt status ignore writes
        if (wr_ok && (reg_addr_i == ADDR_CPSR)) begin
            state_next.cpsr = {reg_wdata_i[CPSR_W-1:1], 1'b0};
        end
        if (wr_ok && (reg_addr_i == ADDR_IMASK)) begin
            state_next.imask = reg_wdata_i[IRQ_W-1:0];
        end

        // Read data stands in the cycle after the strobe only
        // Read data is state too, so it holds while ce_i is low
        if (ce_i) begin
            state_next.rdata = '0;
        end
        if (rd_ok) begin
            case (reg_addr_i)
                ADDR_DATA: begin
                    if (!rx_empty) begin
                        state_next.rdata[DATA_W-1:0] = state_reg.rx_mem[state_reg.rx_rp];
                    end
                end
                ADDR_STATUS: begin
                    state_next.rdata[ST_BUSY] = frame_active_i | !tx_empty;
                    state_next.rdata[ST_RFF] = rx_full;
                    state_next.rdata[ST_RNE] = !rx_empty;
                    state_next.rdata[ST_TNF] = !tx_full;
                    state_next.rdata[ST_TFE] = tx_empty;
                end
                ADDR_CPSR: begin
                    state_next.rdata[CPSR_W-1:0] = state_reg.cpsr;
                end
                ADDR_IMASK: begin
                    state_next.rdata[IRQ_W-1:0] = state_reg.imask;
                end
                ADDR_RIS: begin
                    state_next.rdata[IRQ_W-1:0] = irq_raw;
                end
                ADDR_MIS: begin
                    state_next.rdata[IRQ_W-1:0] = irq_masked;
                end
                default: begin
                    state_next.rdata = '0;
                end
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            state_reg <= '0;
            state_reg.cpsr <= CPSR_RST;
            state_reg.imask <= IMASK_RST;
        end else begin
            state_reg <= state_next;
        end
    end

    assign reg_rdata_o = state_reg.rdata;
    assign bit_tick_o = state_reg.tick;
    assign tx_valid_o = !tx_empty;
    assign tx_data_o = state_reg.tx_mem[state_reg.tx_rp];
    assign tx_fifo_irq_o = irq_masked[IRQ_TX];
    assign rx_fifo_irq_o = irq_masked[IRQ_RX];
    assign rx_timeout_irq_o = irq_masked[IRQ_RT];
    assign rx_overrun_irq_o = irq_masked[IRQ_ROR];
endmodule // ssr_regs
`default_nettype wire

// [ssr_regs_properties.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_regs_properties
    import ssr_pkg::*;
#(
    parameter int FIFO_DEPTH = 8
) (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic ce_i,
    input wire logic [11:0] reg_addr_i,
    input wire logic [31:0] reg_wdata_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic [3:0] frame_size_select_i,
    input wire logic frame_active_i,
    input wire logic tx_valid_o,
    input wire logic [15:0] tx_data_o,
    input wire logic tx_pop_i,
    input wire logic rx_valid_i,
    input wire logic tx_fifo_irq_o,
    input wire logic rx_fifo_irq_o,
    input wire logic rx_timeout_irq_o,
    input wire logic rx_overrun_irq_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    wire logic rd = reg_rd_i & ce_i;
    wire logic wr = reg_wr_i & ce_i;
    wire logic [3:0] irq = {tx_fifo_irq_o, rx_fifo_irq_o, rx_timeout_irq_o, rx_overrun_irq_o};
    property p_rd_quiet; reg_rdata_o != 32'h0 && $past(ce_i) |-> $past(rd); endproperty
    a_rd_quiet: assert property (p_rd_quiet) else $error("stray read data");
    property p_status; rd && reg_addr_i == ADDR_STATUS |=> reg_rdata_o[31:5] == 27'h0
        && reg_rdata_o[4] == $past(frame_active_i | tx_valid_o) && reg_rdata_o[0] == !$past(tx_valid_o);
    endproperty
    a_status: assert property (p_status) else $error("status read wrong");
    property p_cpsr; rd && reg_addr_i == ADDR_CPSR |=> reg_rdata_o[0] == 1'b0; endproperty
    a_cpsr: assert property (p_cpsr) else $error("prescale bit 0 set");
    property p_mis; rd && reg_addr_i == ADDR_MIS |=> reg_rdata_o == {28'h0, $past(irq)}; endproperty
    a_mis: assert property (p_mis) else $error("masked status wrong");
    property p_ror_set; $rose(rx_overrun_irq_o) |-> $past(rx_valid_i | wr); endproperty
    a_ror_set: assert property (p_ror_set) else $error("overrun without frame");
    property p_ror_clr; wr && reg_addr_i == ADDR_ICR && reg_wdata_i[0] && !rx_valid_i
        |=> !rx_overrun_irq_o; endproperty
    a_ror_clr: assert property (p_ror_clr) else $error("overrun not cleared");
    property p_push; wr && reg_addr_i == ADDR_DATA && !tx_valid_o |=> tx_valid_o
        && tx_data_o == ($past(reg_wdata_i[15:0]) & ~(16'hfffe << $past(frame_size_select_i)));
    endproperty
    a_push: assert property (p_push) else $error("push lost or unmasked");
    property p_tx_hold; tx_valid_o && !tx_pop_i |=> tx_valid_o && $stable(tx_data_o); endproperty
    a_tx_hold: assert property (p_tx_hold) else $error("tx head moved");
    c_ovr: cover property (rx_overrun_irq_o);
    c_tmo: cover property (rx_timeout_irq_o);
    c_last: cover property (tx_pop_i && tx_valid_o ##1 !tx_valid_o);
endmodule // ssr_regs_properties
bind ssr_regs ssr_regs_properties #(.FIFO_DEPTH(FIFO_DEPTH)) u_props (.clk_sys_i, .srst_i,
    .ce_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .frame_size_select_i,
    .frame_active_i, .tx_valid_o, .tx_data_o, .tx_pop_i, .rx_valid_i, .tx_fifo_irq_o,
    .rx_fifo_irq_o, .rx_timeout_irq_o, .rx_overrun_irq_o);
`default_nettype wire

// [ssr_link_model.sv]
`timescale 1ns/1ps
`default_nettype none
module ssr_link_model (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire logic stall_i,
    input wire logic bit_tick_i,
    input wire logic tx_valid_i,
    input wire logic [15:0] tx_data_i,
    output logic tx_pop_o,
    output logic rx_valid_o,
    output logic [15:0] rx_data_o,
    output logic frame_active_o
);
    // One frame per bit tick keeps runs short; tx loops back as rx
    always_ff @(posedge clk_sys_i) begin
        tx_pop_o <= 1'b0;
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
        if (bit_tick_i) frame_active_o <= 1'b0;
        if (bit_tick_i && tx_valid_i && !stall_i) begin
            tx_pop_o <= 1'b1;
            rx_valid_o <= 1'b1;
            rx_data_o <= tx_data_i;
            frame_active_o <= 1'b1;
        end
        if (srst_i) begin
            frame_active_o <= 1'b0;
            rx_data_o <= 16'h0;
        end
    end
endmodule // ssr_link_model
`default_nettype wire

// [tb_ssr_regs.sv]
`timescale 1ns/1ps
`default_nettype none
module tb_ssr_regs import ssr_pkg::*;;
    localparam int D = 4;
    logic clk_sys_i = 1'b0, srst_i = 1'b1, stall = 1'b1, wr = 1'b0, rd = 1'b0, rt = 1'b0;
    logic ovr = 1'b0, tick, txv, pop, rxv, fact;
    logic [11:0] addr = 12'h0;
    logic [31:0] wdata = 32'h0, rdata, v;
    logic [3:0] fss = 4'hf;
    logic [3:0] irq;
    logic [7:0] serial_clock_rate = 8'h0;
    logic [15:0] txd, rxd, tq[$], rq[$];
    int err_total = 0, checks = 0, seed = 81, n, i;
    always #12.5 clk_sys_i = ~clk_sys_i;
    ssr_regs #(.FIFO_DEPTH(D)) dut (.clk_sys_i, .srst_i, .ce_i(1'b1), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata),
        .port_enable_i(1'b1), .frame_size_select_i(fss), .serial_clock_rate_i(serial_clock_rate),
        .frame_active_i(fact), .bit_tick_o(tick), .tx_valid_o(txv), .tx_data_o(txd),
        .tx_pop_i(pop), .rx_valid_i(rxv), .rx_data_i(rxd), .tx_fifo_irq_o(irq[3]),
        .rx_fifo_irq_o(irq[2]), .rx_timeout_irq_o(irq[1]), .rx_overrun_irq_o(irq[0]));
    ssr_link_model peer (.clk_sys_i, .srst_i, .stall_i(stall), .bit_tick_i(tick),
        .tx_valid_i(txv), .tx_data_i(txd), .tx_pop_o(pop), .rx_valid_o(rxv),
        .rx_data_o(rxd), .frame_active_o(fact));
    function automatic logic [31:0] st_exp();
        return {27'h0, tq.size() != 0, rq.size() == D, rq.size() != 0, tq.size() != D,
            tq.size() == 0};
    endfunction
    function automatic logic [31:0] ris_exp();
        return {28'h0, tq.size() <= D / 2, rq.size() >= D / 2, rt, ovr};
    endfunction
    task automatic final_report();
        if (err_total == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys_i);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys_i);
        wr <= 1'b0;
    endtask
    task automatic rd_chk(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys_i);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_i);
        rd <= 1'b0;
        #1 chk($sformatf("reg_%h", a), e, rdata);
    endtask
    task automatic push(input logic [15:0] w);
        wr_reg(ADDR_DATA, {16'h0, w});
        if (tq.size() < D) tq.push_back(w & ~(16'hfffe << fss));
    endtask
    // Model moves tx queue into rx, up to D words, once the link has gone quiet; any further word sets ovr
    task automatic drain();
        stall <= 1'b0;
        for (n = 0; n < 500 && txv !== 1'b0; n++) @(posedge clk_sys_i);
        chk("tx_drained", 32'h0, {31'h0, txv});
        repeat (2) @(posedge tick);
        stall <= 1'b1;
        while (tq.size() != 0) begin
            if (rq.size() < D) rq.push_back(tq[0]);
            else ovr = 1'b1;
            void'(tq.pop_front());
        end
    endtask
    task automatic rate(input logic [7:0] cp, input logic [7:0] s);
        wr_reg(ADDR_CPSR, {24'h0, cp});
        serial_clock_rate <= s;
        repeat (2) @(negedge clk_sys_i iff tick);
        for (n = 1; n < 3000; n++) begin
            @(negedge clk_sys_i);
            if (tick) break;
        end
        chk("tick_period", 32'(cp * (s + 1)), n);
        @(posedge clk_sys_i);
    endtask
    initial begin
        #2000000;
        err_total++;
        final_report();
    end
    initial begin
        repeat (2) @(posedge clk_sys_i);
        srst_i <= 1'b0;
        rd_chk(ADDR_STATUS, st_exp());
        rd_chk(ADDR_RIS, ris_exp());
        rd_chk(ADDR_IMASK, 32'h0);
        chk("irq_pins", 32'h0, {28'h0, irq});
        rd_chk(ADDR_CPSR, 32'h0);
        rd_chk(12'h040, 32'h0);
        wr_reg(ADDR_RIS, 32'hffffffff);
        rd_chk(ADDR_RIS, ris_exp());
        v = $random(seed);
        wr_reg(ADDR_CPSR, v);
        rd_chk(ADDR_CPSR, {24'h0, v[7:1], 1'b0});
        wr_reg(ADDR_IMASK, 32'hffffffff);
        rd_chk(ADDR_IMASK, 32'hf);
        // Slowest rate last keeps the timeout away while rx holds data
        for (i = 0; i < 3; i++) rate(8'h2 << i, i[7:0]);
        fss <= 4'($unsigned($random(seed)) % 13 + 3);
        for (i = 0; i < D + 2; i++) push($random(seed));
        rd_chk(ADDR_STATUS, st_exp());
        rd_chk(ADDR_MIS, ris_exp());
        chk("irq_pins", ris_exp(), {28'h0, irq});
        drain();
        rd_chk(ADDR_STATUS, st_exp());
        rd_chk(ADDR_RIS, ris_exp());
        push($random(seed));
        drain();
        rd_chk(ADDR_RIS, ris_exp());
        wr_reg(ADDR_ICR, 32'h0);
        rd_chk(ADDR_MIS, ris_exp());
        wr_reg(ADDR_ICR, 32'h1);
        ovr = 1'b0;
        rd_chk(ADDR_RIS, ris_exp());
        while (rq.size() != 0) rd_chk(ADDR_DATA, rq.pop_front());
        rd_chk(ADDR_DATA, 32'h0);
        push($random(seed));
        drain();
        repeat (40) @(posedge tick);
        rt = 1'b1;
        rd_chk(ADDR_RIS, ris_exp());
        chk("irq_pins", ris_exp(), {28'h0, irq});
        @(posedge tick);
        wr_reg(ADDR_ICR, 32'h2);
        rt = 1'b0;
        rd_chk(ADDR_RIS, ris_exp());
        final_report();
    end
endmodule // tb_ssr_regs
`default_nettype wire
